// ==== hdl/hprc_config_bank.sv ====
/*
 * Hub port role and clock configuration bank: three byte registers on a
 * plain strobe bus, suspend clock gating, per-port PHY clock stop, power
 * pin port select and upstream/downstream role swap mapping.
 * Assumes strobes synchronous to clk_sys and never both in one cycle.
 */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "hprc_regs.svh"

module hprc_config_bank
	import hprc_pkg::*;
(
	input  wire logic                        clk_sys,
	input  wire logic                        sys_rst,
	input  wire logic [`HPRC_ADDR_W-1:0]     regAddr,
	input  wire logic [7:0]                  regWdata,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic      [7:0]                  regRdata,
	input  wire logic                        usbSuspend,
	input  wire logic [`HPRC_NUM_LPORTS-1:0] logicalPortSetting,
	input  wire logic [1:0]                  physChargerSetting,
	output logic                             internalClockEnable,
	output logic      [4:0]                  portPhyClockOff,
	output logic      [3:0]                  portPowerPinOneHot,
	output logic                             roleSwapMode,
	output logic                             phys0Upstream,
	output logic                             phys1Upstream,
	output logic      [`HPRC_NUM_LPORTS-1:0] physicalPortSetting,
	output logic      [1:0]                  physChargerOut
);

	hprc_bus_t  bus;
	hprc_sel_t  wrSel;
	hprc_sel_t  rdSel;
	logic [7:0] rdData;
	logic [7:0] regPortable;
	logic [7:0] regPsel;
	logic [7:0] regConnect;
	hprc_cfg_t  cfg;
	logic [`HPRC_NUM_LPORTS-1:0] mapOut;
	logic       map0Up;
	logic       map1Up;

	logic                        next_internalClockEnable;
	logic [4:0]                  next_portPhyClockOff;
	logic [3:0]                  next_portPowerPinOneHot;
	logic                        next_roleSwapMode;
	logic                        next_phys0Upstream;
	logic                        next_phys1Upstream;
	logic [`HPRC_NUM_LPORTS-1:0] next_physicalPortSetting;
	logic [1:0]                  next_physChargerOut;

	assign bus   = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
	assign wrSel = bus.wr ? hprc_decode(bus.addr) : HPRC_SEL_NONE;
	assign rdSel = bus.rd ? hprc_decode(bus.addr) : HPRC_SEL_NONE;

	// Unmapped reads return zero through index 0
	hprc_reg_mem u_mem (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.wrEn        (wrSel != HPRC_SEL_NONE),
		.wrIdx       (wrSel),
		.wrData      (bus.wdata),
		.rdEn        (bus.rd),
		.rdIdx       (rdSel),
		.rdData      (rdData),
		.regPortable (regPortable),
		.regPsel     (regPsel),
		.regConnect  (regConnect)
	);

	assign regRdata = rdData;

	assign cfg.clkKeep            = regPortable[`HPRC_BIT_CLK_KEEP];
	assign cfg.phyClockOff        = regPortable[`HPRC_PHYOFF_HI:`HPRC_PHYOFF_LO];
	assign cfg.powerPinPortSelect = regPsel[`HPRC_PSEL_HI:`HPRC_PSEL_LO];
	assign cfg.swapEnable         = regConnect[`HPRC_BIT_SWAP_EN];
	assign cfg.swapControl        = regConnect[`HPRC_BIT_SWAP_CTL];

	hprc_role_map u_map (
		.swapControl   (cfg.swapControl),
		.logicalIn     (logicalPortSetting),
		.physicalOut   (mapOut),
		.phys0Upstream (map0Up),
		.phys1Upstream (map1Up)
	);

	// Selection is taken as programmed; software keeps it stable in session
	always_comb begin
		next_internalClockEnable = !usbSuspend || cfg.clkKeep;
		next_portPhyClockOff     = cfg.phyClockOff;
		next_portPowerPinOneHot  = 4'h1 << cfg.powerPinPortSelect;
		next_roleSwapMode        = cfg.swapEnable;
		next_phys0Upstream       = map0Up;
		next_phys1Upstream       = map1Up;
		next_physicalPortSetting = mapOut;
		next_physChargerOut      = physChargerSetting;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			internalClockEnable <= 1'b1;
			portPhyClockOff     <= 5'h00;
			portPowerPinOneHot  <= 4'h1;
			roleSwapMode        <= 1'b0;
			phys0Upstream       <= 1'b1;
			phys1Upstream       <= 1'b0;
			physicalPortSetting <= 4'h0;
			physChargerOut      <= 2'h0;
		end else begin
			internalClockEnable <= next_internalClockEnable;
			portPhyClockOff     <= next_portPhyClockOff;
			portPowerPinOneHot  <= next_portPowerPinOneHot;
			roleSwapMode        <= next_roleSwapMode;
			phys0Upstream       <= next_phys0Upstream;
			phys1Upstream       <= next_phys1Upstream;
			physicalPortSetting <= next_physicalPortSetting;
			physChargerOut      <= next_physChargerOut;
		end
	end

endmodule : hprc_config_bank

`default_nettype wire

// ==== hdl/hprc_pkg.sv ====
/*
 * Types shared by the configuration bank and its helpers.
 * Assumes the register header is on the include path.
 */
`include "hprc_regs.svh"

package hprc_pkg;

	typedef struct packed {
		logic [`HPRC_ADDR_W-1:0] addr;
		logic [7:0]              wdata;
		logic                    wr;
		logic                    rd;
	} hprc_bus_t;

	typedef enum logic [1:0] {
		HPRC_SEL_NONE,
		HPRC_SEL_PORTABLE,
		HPRC_SEL_PSEL,
		HPRC_SEL_CONNECT
	} hprc_sel_t;

	typedef struct packed {
		logic       clkKeep;
		logic [4:0] phyClockOff;
		logic [1:0] powerPinPortSelect;
		logic       swapEnable;
		logic       swapControl;
	} hprc_cfg_t;

	function automatic hprc_sel_t hprc_decode(input logic [`HPRC_ADDR_W-1:0] a);
		case (a)
			`HPRC_OFS_PORTABLE_CFG: hprc_decode = HPRC_SEL_PORTABLE;
			`HPRC_OFS_PORT_SELECT:  hprc_decode = HPRC_SEL_PSEL;
			`HPRC_OFS_CONNECT_CFG:  hprc_decode = HPRC_SEL_CONNECT;
			default:                hprc_decode = HPRC_SEL_NONE;
		endcase
	endfunction : hprc_decode

endpackage : hprc_pkg

// ==== hdl/hprc_reg_mem.sv ====
/*
 * Three-byte register store with per-entry write mask and registered read.
 * Assumes one write or one read per cycle from the bank front end.
 */
`timescale 1ns/1ps
`default_nettype none

`include "hprc_regs.svh"

module hprc_reg_mem
	import hprc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       wrEn,
	input  wire logic [1:0] wrIdx,
	input  wire logic [7:0] wrData,
	input  wire logic       rdEn,
	input  wire logic [1:0] rdIdx,
	output logic      [7:0] rdData,
	output logic      [7:0] regPortable,
	output logic      [7:0] regPsel,
	output logic      [7:0] regConnect
);

	logic [7:0] next_regPortable;
	logic [7:0] next_regPsel;
	logic [7:0] next_regConnect;
	logic [7:0] next_rdData;

	function automatic logic [7:0] mergeMasked(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m);
		mergeMasked = (old & ~m) | (nw & m);
	endfunction : mergeMasked

	always_comb begin
		next_regPortable = regPortable;
		next_regPsel     = regPsel;
		next_regConnect  = regConnect;
		next_rdData      = 8'h00;
		if (wrEn) begin
			case (wrIdx)
				2'h1: next_regPortable = mergeMasked(regPortable, wrData,
					`HPRC_WMASK_PORTABLE_CFG);
				2'h2: next_regPsel = mergeMasked(regPsel, wrData,
					`HPRC_WMASK_PORT_SELECT);
				2'h3: next_regConnect = mergeMasked(regConnect, wrData,
					`HPRC_WMASK_CONNECT_CFG);
				default: ;
			endcase
		end
		if (rdEn) begin
			case (rdIdx)
				2'h1:    next_rdData = regPortable;
				2'h2:    next_rdData = regPsel;
				2'h3:    next_rdData = regConnect;
				default: next_rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			regPortable <= `HPRC_RST_PORTABLE_CFG;
			regPsel     <= `HPRC_RST_PORT_SELECT;
			regConnect  <= `HPRC_RST_CONNECT_CFG;
			rdData      <= 8'h00;
		end else begin
			regPortable <= next_regPortable;
			regPsel     <= next_regPsel;
			regConnect  <= next_regConnect;
			rdData      <= next_rdData;
		end
	end

endmodule : hprc_reg_mem

`default_nettype wire

// ==== hdl/hprc_regs.svh ====
/*
 * Register offsets, field positions, reset values and write masks of the
 * hub port role and clock configuration bank.
 * Assumes inclusion by its bare name from package and modules.
 */
`ifndef HPRC_REGS_SVH
`define HPRC_REGS_SVH

`define HPRC_ADDR_W             16
`define HPRC_OFS_PORTABLE_CFG   16'h30EE
`define HPRC_OFS_PORT_SELECT    16'h318B
`define HPRC_OFS_CONNECT_CFG    16'h318E

`define HPRC_RST_PORTABLE_CFG   8'h10
`define HPRC_RST_PORT_SELECT    8'h00
`define HPRC_RST_CONNECT_CFG    8'h00

`define HPRC_WMASK_PORTABLE_CFG 8'hBE
`define HPRC_WMASK_PORT_SELECT  8'hC0
`define HPRC_WMASK_CONNECT_CFG  8'h03

`define HPRC_BIT_CLK_KEEP       7
`define HPRC_PHYOFF_HI          5
`define HPRC_PHYOFF_LO          1
`define HPRC_PSEL_HI            7
`define HPRC_PSEL_LO            6
`define HPRC_BIT_SWAP_EN        1
`define HPRC_BIT_SWAP_CTL       0

`define HPRC_NUM_LPORTS         4
`define HPRC_NUM_REGS           3

`endif

// ==== hdl/hprc_role_map.sv ====
/*
 * Logical to physical port mapping for the upstream/downstream role swap.
 * Assumes logical port 0 is upstream and logical port 1 the swap partner.
 */
`timescale 1ns/1ps
`default_nettype none

`include "hprc_regs.svh"

module hprc_role_map
	import hprc_pkg::*;
(
	input  wire logic                        swapControl,
	input  wire logic [`HPRC_NUM_LPORTS-1:0] logicalIn,
	output logic      [`HPRC_NUM_LPORTS-1:0] physicalOut,
	output logic                             phys0Upstream,
	output logic                             phys1Upstream
);

	always_comb begin
		physicalOut = logicalIn;
		phys0Upstream = 1'b1;
		phys1Upstream = 1'b0;
		if (swapControl) begin
			physicalOut[0] = logicalIn[1];
			physicalOut[1] = logicalIn[0];
			phys0Upstream = 1'b0;
			phys1Upstream = 1'b1;
		end
	end

endmodule : hprc_role_map

`default_nettype wire

// ==== verif/hprc_config_bank_checker.sv ====
/*
 * Port-level assertions and covers for the configuration bank.
 * Assumes one clock, clk_sys, and synchronous active-high sys_rst.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hprc_regs.svh"

module hprc_config_bank_checker
	import hprc_pkg::*;
(
	input wire logic	clk_sys,
	input wire logic	sys_rst,
	input wire logic [15:0]	regAddr,
	input wire logic [7:0]	regWdata,
	input wire logic	regWr,
	input wire logic	regRd,
	input wire logic [7:0]	regRdata,
	input wire logic	usbSuspend,
	input wire logic [3:0]	logicalPortSetting,
	input wire logic [1:0]	physChargerSetting,
	input wire logic	internalClockEnable,
	input wire logic [4:0]	portPhyClockOff,
	input wire logic [3:0]	portPowerPinOneHot,
	input wire logic	roleSwapMode,
	input wire logic	phys0Upstream,
	input wire logic	phys1Upstream,
	input wire logic [3:0]	physicalPortSetting,
	input wire logic [1:0]	physChargerOut
);
	localparam logic [15:0] A0 = 16'h30EE, A1 = 16'h318B, A2 = 16'h318E;
	logic [7:0] rsvMask;
	logic [3:0] lpQ;
	logic [1:0] chQ;
	// Bits that must read zero at the strobed address
	assign rsvMask = regAddr == A0 ? 8'h41 : regAddr == A1 ? 8'h3F : regAddr == A2 ? 8'hFC : 8'hFF;
	always_ff @(posedge clk_sys) begin
		lpQ <= logicalPortSetting;
		chQ <= physChargerSetting;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_rdIdle; !regRd |=> regRdata == 8'h00; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
	property p_rsv; regRd |=> (regRdata & $past(rsvMask)) == 8'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	property p_gate; !internalClockEnable |-> $past(usbSuspend); endproperty
	a_gate: assert property (p_gate) else $error("clock gated outside suspend");
	property p_keep;
		regWr && regAddr == A0 && regWdata[7] ##1 usbSuspend |=> internalClockEnable;
	endproperty
	a_keep: assert property (p_keep) else $error("clock gated despite keep bit");
	property p_phy;
		regWr && regAddr == A0 |=> ##1 portPhyClockOff == $past(regWdata[5:1], 2);
	endproperty
	a_phy: assert property (p_phy) else $error("phy clock off mismatch");
	property p_psel;
		regWr && regAddr == A1 |=> ##1 portPowerPinOneHot == 4'h1 << $past(regWdata[7:6], 2);
	endproperty
	a_psel: assert property (p_psel) else $error("power pin select mismatch");
	property p_role; phys0Upstream != phys1Upstream; endproperty
	a_role: assert property (p_role) else $error("upstream role not unique");
	property p_swap;
		regWr && regAddr == A2 |=> ##1 phys1Upstream == $past(regWdata[0], 2)
			&& roleSwapMode == $past(regWdata[1], 2);
	endproperty
	a_swap: assert property (p_swap) else $error("role swap mismatch");
	property p_map;
		!$past(sys_rst) |-> physicalPortSetting ==
			(phys1Upstream ? {lpQ[3:2], lpQ[0], lpQ[1]} : lpQ);
	endproperty
	a_map: assert property (p_map) else $error("logical port mapping mismatch");
	property p_chg; !$past(sys_rst) |-> physChargerOut == chQ; endproperty
	a_chg: assert property (p_chg) else $error("charger setting moved");
	c_swap: cover property (regWr && regAddr == A2 && regWdata[0]);
	c_gate: cover property (!internalClockEnable);
	c_read: cover property (regRd && regAddr == A0);
endmodule : hprc_config_bank_checker

bind hprc_config_bank hprc_config_bank_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.usbSuspend(usbSuspend), .logicalPortSetting(logicalPortSetting),
	.physChargerSetting(physChargerSetting), .internalClockEnable(internalClockEnable),
	.portPhyClockOff(portPhyClockOff), .portPowerPinOneHot(portPowerPinOneHot),
	.roleSwapMode(roleSwapMode), .phys0Upstream(phys0Upstream), .phys1Upstream(phys1Upstream),
	.physicalPortSetting(physicalPortSetting), .physChargerOut(physChargerOut));
`default_nettype wire

// ==== verif/hprc_config_bank_tb_top.sv ====
/*
 * Self-checking bench for the configuration bank over its strobe bus.
 * Assumes the checker is bound in by its own file.
 */
`timescale 1ns/1ps
`default_nettype none

module hprc_config_bank_tb_top;
	logic clk_sys = 0, sys_rst = 1, regWr = 0, regRd = 0, usbSuspend = 0;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0] regWdata = 8'h00, regRdata;
	logic [3:0] logicalPortSetting = 4'h0, physicalPortSetting, portPowerPinOneHot;
	logic [1:0] physChargerSetting = 2'h0, physChargerOut;
	logic [4:0] portPhyClockOff;
	logic internalClockEnable, roleSwapMode, phys0Upstream, phys1Upstream;
	logic [15:0] ad [3] = '{16'h30EE, 16'h318B, 16'h318E};
	logic [7:0] mk [3] = '{8'hBE, 8'hC0, 8'h03};
	int miscompares = 0, samples_checked = 0;
	always #10 clk_sys = ~clk_sys;
	hprc_config_bank u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.usbSuspend(usbSuspend), .logicalPortSetting(logicalPortSetting),
		.physChargerSetting(physChargerSetting), .internalClockEnable(internalClockEnable),
		.portPhyClockOff(portPhyClockOff), .portPowerPinOneHot(portPowerPinOneHot),
		.roleSwapMode(roleSwapMode), .phys0Upstream(phys0Upstream), .phys1Upstream(phys1Upstream),
		.physicalPortSetting(physicalPortSetting), .physChargerOut(physChargerOut));
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk("regRdata", regRdata, e);
	endtask : rd
	task settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle
	task close_out;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	initial begin
		#200000;
		miscompares++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(16'h30EE, 8'h10);
		chk("portPhyClockOff", portPhyClockOff, 8'h08);
		for (int i = 0; i < 3; i++) begin
			wr(ad[i], 8'hFF);
			rd(ad[i], mk[i]);
		end
		wr(16'h30ED, 8'hFF);
		rd(16'h30ED, 8'h00);
		for (int n = 1; n < 6; n++) begin
			wr(16'h30EE, 8'h01 << n);
			settle();
			chk("portPhyClockOff", portPhyClockOff, 8'h01 << (n - 1));
		end
		@(posedge clk_sys) usbSuspend <= 1'b1;
		settle();
		chk("internalClockEnable", internalClockEnable, 8'h00);
		wr(16'h30EE, 8'h80);
		settle();
		chk("internalClockEnable", internalClockEnable, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(16'h318B, 8'(k << 6));
			settle();
			chk("portPowerPinOneHot", portPowerPinOneHot, 8'h01 << k);
		end
		@(posedge clk_sys) logicalPortSetting <= 4'b1001;
		physChargerSetting <= 2'b01;
		wr(16'h318E, 8'h00);
		settle();
		chk("phys0Upstream", phys0Upstream, 8'h01);
		chk("physicalPortSetting", physicalPortSetting, 8'h09);
		chk("roleSwapMode", roleSwapMode, 8'h00);
		wr(16'h318E, 8'h03);
		settle();
		chk("phys1Upstream", phys1Upstream, 8'h01);
		chk("physicalPortSetting", physicalPortSetting, 8'h0A);
		chk("roleSwapMode", roleSwapMode, 8'h01);
		chk("physChargerOut", physChargerOut, 8'h01);
		// Private channel under swap: every exposed PHY clock stopped
		wr(16'h30EE, 8'h3E);
		settle();
		chk("portPhyClockOff", portPhyClockOff, 8'h1F);
		// Mid-run reset returns swap and keep bit to defaults
		@(posedge clk_sys) sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(16'h318E, 8'h00);
		chk("phys0Upstream", phys0Upstream, 8'h01);
		chk("internalClockEnable", internalClockEnable, 8'h00);
		close_out();
	end
endmodule : hprc_config_bank_tb_top
`default_nettype wire
